// ===== verilog/flm_pkg.sv
// Shared constants and types for the current and temperature limit monitor
`default_nettype none
package flm_pkg;
   // Command codes
   localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
   localparam logic [7:0] CMD_OC_FAULT = 8'h46;
   localparam logic [7:0] CMD_OC_WARN = 8'h4A;
   localparam logic [7:0] CMD_UC_FAULT = 8'h4B;
   localparam logic [7:0] CMD_OT_FAULT = 8'h4F;
   localparam logic [7:0] CMD_OT_ACTION = 8'h50;
   localparam logic [7:0] CMD_OT_WARN = 8'h51;
   localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
   localparam logic [7:0] CMD_STATUS_IOUT = 8'h7B;
   localparam logic [7:0] CMD_STATUS_TEMP = 8'h7D;
   localparam logic [7:0] CMD_STATUS_VENDOR = 8'h80;
   // Reset values
   localparam logic [15:0] RST_OC_FAULT = 16'hE2D0;
   localparam logic [15:0] RST_OC_WARN = 16'hDBC0;
   localparam logic [15:0] RST_UC_FAULT = 16'hE530;
   localparam logic [15:0] RST_OT_FAULT = 16'hEBE8;
   localparam logic [15:0] RST_OT_WARN = 16'hEB70;
   localparam logic [7:0] RST_OT_ACTION = 8'h80;
   // Field positions
   localparam int L11_EXP_LSB = 11;
   localparam int IOUT_OC_FAULT_BIT = 7;
   localparam int IOUT_OC_WARN_BIT = 5;
   localparam int IOUT_UC_FAULT_BIT = 4;
   localparam int TEMP_OT_FAULT_BIT = 7;
   localparam int VENDOR_OT_BIT = 1;
   localparam int WORD_IOUT_BIT = 14;
   localparam int WORD_TEMP_BIT = 2;
   localparam logic [1:0] ACT_DISABLE_RETRY = 2'b10;
   // Samples are signed, 1/16 unit per LSB
   localparam int FRAC_BITS = 4;
   localparam logic signed [31:0] CUR_MAX = 32'sh0000_0640;
   localparam logic signed [31:0] CUR_MIN = -32'sh0000_0640;
   localparam logic signed [31:0] TEMP_MAX = 32'sh0000_0AF0;
   // Retry timing
   localparam int CLK_HZ = 20_000_000;
   localparam int RETRY_UNIT_MS = 35;
   localparam int RETRY_UNIT_CYC = CLK_HZ / 1000 * RETRY_UNIT_MS;

   typedef enum {OT_RUN, OT_HOLD, OT_COOL, OT_LATCHED} flm_ot_state_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] code;
      logic [15:0] wdata;
   } flm_cmd_t;

   typedef struct packed {
      logic valid;
      logic blank_done;
      logic signed [15:0] value;
   } flm_sample_t;

   // Linear-11 word to fixed point with FRAC_BITS fraction bits
   function automatic logic signed [31:0] l11_to_fix(input logic [15:0] v);
      logic signed [31:0] m;
      int e;
      m = 32'(signed'(v[10:0]));
      e = int'(signed'(v[15:L11_EXP_LSB])) + FRAC_BITS;
      if (e >= 0)
         return m <<< e;
      return m >>> (-e);
   endfunction
endpackage
`default_nettype wire

// ===== verilog/flm_monitor.sv
// Current and temperature limit monitor with over-temperature retry control
// How it works
// [R1] Current compared only after blanking ends; temperature ignores blanking
// [R2] Overcurrent fault after N consecutive exceeding samples
// [R3] Peak and averaged overcurrent share one bit
// [R4] Out-of-range limit writes are rejected
// [R5] Overcurrent warning resets to DBC0 (30A)
// [R6] Qualified warning sets output-current warning bit
// [R7] Host keeps warning below fault limit
// [R8] Undercurrent qualified alike, shares bit with average
// [R9] Over-temperature sets summary, fault bit, alerts
// [R10] Over-temperature also recorded in vendor bit one
// [R11] Retry waits until temperature below warning
// [R12] Host keeps temperature warning below fault
// [R13] Over-temperature limit resets to 125 degrees
// [R14] Action byte delay sets restart interval
// [R15] 10 disables; retry field; (d+1)*35ms delay
// [R16] Faults pull alert low until clear
// [R17] Limits decoded as Linear-11 exponent and mantissa
// [R18] Undercurrent trips below limit; misses restart count
`timescale 1ns/1ps
`default_nettype none
module flm_monitor #(
   parameter int CNT_W = 4,
   parameter int RETRY_UNIT = flm_pkg::RETRY_UNIT_CYC
) (
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire flm_pkg::flm_cmd_t cmd_in,
   input wire flm_pkg::flm_sample_t cur_in,
   input wire flm_pkg::flm_sample_t temp_in,
   input wire logic [CNT_W-1:0] consec_count_in,
   input wire logic avg_oc_fault_in,
   input wire logic avg_uc_fault_in,
   output logic [15:0] cmd_rdata_out,
   output logic cmd_ack_out,
   output logic cmd_reject_out,
   output logic alert_output_pin_n_out,
   output logic [7:0] iout_status_out,
   output logic [7:0] temp_status_out,
   output logic [7:0] vendor_status_out,
   output logic output_disable_out,
   output logic restart_out
);
   logic [15:0] oc_lim, ocw_lim, uc_lim, ot_lim, otw_lim, next_oc_lim, next_ocw_lim;
   logic [15:0] next_uc_lim, next_ot_lim, next_otw_lim;
   logic [7:0] ot_act, next_ot_act;
   logic [15:0] rdata, next_rdata;
   logic ack, rej, next_ack, next_rej;
   logic signed [31:0] wfix;
   logic clr;
   // Status state is read by the command decode, so it is declared up front
   logic [7:0] iout_st, temp_st, vend_st, next_iout_st, next_temp_st, next_vend_st;
   logic [15:0] status_word;

   // Limit decode and range test on the incoming word
   assign wfix = flm_pkg::l11_to_fix(cmd_in.wdata); // [R17]
   assign clr = cmd_in.wr && cmd_in.code == flm_pkg::CMD_CLEAR_FAULTS;

   // Command decode; a rejected write leaves the limit untouched
   always_comb begin
      next_oc_lim = oc_lim;
      next_ocw_lim = ocw_lim;
      next_uc_lim = uc_lim;
      next_ot_lim = ot_lim;
      next_otw_lim = otw_lim;
      next_ot_act = ot_act;
      next_rdata = rdata;
      next_ack = 1'b0;
      next_rej = 1'b0;
      if (cmd_in.wr) begin
         next_ack = 1'b1;
         case (cmd_in.code)
            flm_pkg::CMD_CLEAR_FAULTS: ;
            flm_pkg::CMD_OC_FAULT, flm_pkg::CMD_OC_WARN: begin
               if (wfix < 0 || wfix > flm_pkg::CUR_MAX) begin
                  next_rej = 1'b1; // [R4]
               end else if (cmd_in.code == flm_pkg::CMD_OC_FAULT) begin
                  next_oc_lim = cmd_in.wdata;
               end else begin
                  next_ocw_lim = cmd_in.wdata;
               end
            end
            flm_pkg::CMD_UC_FAULT: begin
               if (wfix > 0 || wfix < flm_pkg::CUR_MIN)
                  next_rej = 1'b1; // [R4]
               else
                  next_uc_lim = cmd_in.wdata;
            end
            flm_pkg::CMD_OT_FAULT, flm_pkg::CMD_OT_WARN: begin
               if (wfix < 0 || wfix > flm_pkg::TEMP_MAX) begin
                  next_rej = 1'b1; // [R4]
               end else if (cmd_in.code == flm_pkg::CMD_OT_FAULT) begin
                  next_ot_lim = cmd_in.wdata;
               end else begin
                  next_otw_lim = cmd_in.wdata;
               end
            end
            flm_pkg::CMD_OT_ACTION: next_ot_act = cmd_in.wdata[7:0]; // [R14]
            default: next_rej = 1'b1;
         endcase
      end else if (cmd_in.rd) begin
         next_ack = 1'b1;
         case (cmd_in.code)
            flm_pkg::CMD_OC_FAULT: next_rdata = oc_lim;
            flm_pkg::CMD_OC_WARN: next_rdata = ocw_lim;
            flm_pkg::CMD_UC_FAULT: next_rdata = uc_lim;
            flm_pkg::CMD_OT_FAULT: next_rdata = ot_lim;
            flm_pkg::CMD_OT_WARN: next_rdata = otw_lim;
            flm_pkg::CMD_OT_ACTION: next_rdata = {8'h00, ot_act};
            flm_pkg::CMD_STATUS_WORD: next_rdata = status_word;
            flm_pkg::CMD_STATUS_IOUT: next_rdata = {8'h00, iout_st};
            flm_pkg::CMD_STATUS_TEMP: next_rdata = {8'h00, temp_st};
            flm_pkg::CMD_STATUS_VENDOR: next_rdata = {8'h00, vend_st};
            default: begin
               next_rdata = 16'h0000;
               next_rej = 1'b1;
            end
         endcase
      end
   end

   // Limit registers and command answer
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         oc_lim <= flm_pkg::RST_OC_FAULT;
         ocw_lim <= flm_pkg::RST_OC_WARN; // [R5]
         uc_lim <= flm_pkg::RST_UC_FAULT;
         ot_lim <= flm_pkg::RST_OT_FAULT; // [R13]
         otw_lim <= flm_pkg::RST_OT_WARN;
         ot_act <= flm_pkg::RST_OT_ACTION;
         rdata <= 16'h0000;
         ack <= 1'b0;
         rej <= 1'b0;
      end else begin
         oc_lim <= next_oc_lim;
         ocw_lim <= next_ocw_lim;
         uc_lim <= next_uc_lim;
         ot_lim <= next_ot_lim;
         otw_lim <= next_otw_lim;
         ot_act <= next_ot_act;
         rdata <= next_rdata;
         ack <= next_ack;
         rej <= next_rej;
      end
   end

   // Consecutive-sample qualifiers: 0 oc fault, 1 oc warn, 2 uc fault
   logic qual;
   logic signed [31:0] cur_fix;
   logic [2:0] hit, trip;
   logic [CNT_W-1:0] need;
   assign qual = cur_in.valid && cur_in.blank_done; // [R1]
   assign cur_fix = 32'(cur_in.value);
   assign need = (consec_count_in == '0) ? CNT_W'(1) : consec_count_in;
   assign hit[0] = cur_fix > flm_pkg::l11_to_fix(oc_lim);
   assign hit[1] = cur_fix > flm_pkg::l11_to_fix(ocw_lim);
   assign hit[2] = cur_fix < flm_pkg::l11_to_fix(uc_lim); // [R18]

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_qual
         logic [CNT_W-1:0] cnt, next_cnt;
         // Saturating run count; any miss starts over
         always_comb begin
            next_cnt = cnt;
            if (qual)
               next_cnt = hit[gi] ? ((cnt == '1) ? cnt : cnt + CNT_W'(1)) : '0; // [R18]
         end
         // Compare against need-1 so the current hit completes the run of need samples
         assign trip[gi] = qual && hit[gi] && (cnt >= need - CNT_W'(1)); // [R2] [R8]
         always_ff @(posedge mclk_in or negedge resetn_in) begin
            if (!resetn_in)
               cnt <= '0;
            else
               cnt <= next_cnt;
         end
      end
   endgenerate

   // Temperature compare and sticky status; a set beats a same-cycle clear
   logic ot_trip, cool;
   assign ot_trip = temp_in.valid && 32'(temp_in.value) > flm_pkg::l11_to_fix(ot_lim);
   assign cool = temp_in.valid && 32'(temp_in.value) < flm_pkg::l11_to_fix(otw_lim); // [R11]
   always_comb begin
      next_iout_st = clr ? 8'h00 : iout_st; // [R16]
      next_temp_st = clr ? 8'h00 : temp_st;
      next_vend_st = clr ? 8'h00 : vend_st;
      if (trip[0] || avg_oc_fault_in)
         next_iout_st[flm_pkg::IOUT_OC_FAULT_BIT] = 1'b1; // [R3]
      if (trip[1])
         next_iout_st[flm_pkg::IOUT_OC_WARN_BIT] = 1'b1; // [R6]
      if (trip[2] || avg_uc_fault_in)
         next_iout_st[flm_pkg::IOUT_UC_FAULT_BIT] = 1'b1; // [R8]
      if (ot_trip) begin
         next_temp_st[flm_pkg::TEMP_OT_FAULT_BIT] = 1'b1; // [R9]
         next_vend_st[flm_pkg::VENDOR_OT_BIT] = 1'b1; // [R10]
      end
   end
   always_comb begin
      status_word = 16'h0000;
      status_word[flm_pkg::WORD_IOUT_BIT] = |iout_st;
      status_word[flm_pkg::WORD_TEMP_BIT] = |temp_st; // [R9]
   end

   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         iout_st <= 8'h00;
         temp_st <= 8'h00;
         vend_st <= 8'h00;
      end else begin
         iout_st <= next_iout_st;
         temp_st <= next_temp_st;
         vend_st <= next_vend_st;
      end
   end

   // Over-temperature response; restart only once cooled below warning
   flm_pkg::flm_ot_state_t st, next_st;
   logic [31:0] tmr, next_tmr, delay_cyc;
   logic dis, next_dis, rst_pulse, next_rst_pulse;
   assign delay_cyc = (32'(ot_act[2:0]) + 32'h1) * 32'(RETRY_UNIT); // [R15]
   always_comb begin
      next_st = st;
      next_tmr = tmr;
      next_dis = dis;
      next_rst_pulse = 1'b0;
      case (st)
         flm_pkg::OT_RUN: begin
            if (ot_trip && ot_act[7:6] == flm_pkg::ACT_DISABLE_RETRY) begin
               next_dis = 1'b1; // [R15]
               next_tmr = 32'h0;
               next_st = (ot_act[5:3] == 3'b000) ? flm_pkg::OT_LATCHED : flm_pkg::OT_HOLD;
            end
         end
         flm_pkg::OT_HOLD: begin
            next_tmr = tmr + 32'h1;
            if (tmr + 32'h1 >= delay_cyc)
               next_st = flm_pkg::OT_COOL; // [R14]
         end
         flm_pkg::OT_COOL: begin
            if (cool) begin
               next_dis = 1'b0; // [R11]
               next_rst_pulse = 1'b1;
               next_st = flm_pkg::OT_RUN;
            end
         end
         flm_pkg::OT_LATCHED: begin
            if (clr) begin
               next_dis = 1'b0;
               next_st = flm_pkg::OT_RUN;
            end
         end
         default: next_st = flm_pkg::OT_RUN;
      endcase
   end
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         st <= flm_pkg::OT_RUN;
         tmr <= 32'h0;
         dis <= 1'b0;
         rst_pulse <= 1'b0;
      end else begin
         st <= next_st;
         tmr <= next_tmr;
         dis <= next_dis;
         rst_pulse <= next_rst_pulse;
      end
   end

   // Registered outputs; alert follows next status so it lands with the bits
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in)
         alert_output_pin_n_out <= 1'b1;
      else
         alert_output_pin_n_out <= ~(|{next_iout_st, next_temp_st, next_vend_st}); // [R16]
   end
   assign cmd_rdata_out = rdata;
   assign cmd_ack_out = ack;
   assign cmd_reject_out = rej;
   assign iout_status_out = iout_st;
   assign temp_status_out = temp_st;
   assign vendor_status_out = vend_st;
   assign output_disable_out = dis;
   assign restart_out = rst_pulse;

   a_blank_gate: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      !cur_in.blank_done |-> trip == 3'b000) else $error("trip without blanking end"); // [R1]
   a_oc_fault_set: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      trip[0] |=> iout_st[flm_pkg::IOUT_OC_FAULT_BIT]) else $error("oc fault bit not set"); // [R2]
   a_avg_shared: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      avg_oc_fault_in |=> iout_st[7]) else $error("avg oc not on shared bit"); // [R3]
   a_reject_keeps: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      rej && $past(cmd_in.wr) |-> $stable(oc_lim) && $stable(ot_lim))
      else $error("rejected write changed limit"); // [R4]
   a_warn_set: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      trip[1] && !clr |=> iout_st[5]) else $error("warn bit not set"); // [R6]
   a_uc_set: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      trip[2] |=> iout_st[4]) else $error("uc bit not set"); // [R8]
   a_ot_records: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      ot_trip |=> temp_st[7] && vend_st[1] && status_word[2]) else $error("ot not recorded"); // [R9]
   a_retry_cool: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      rst_pulse |-> $past(cool)) else $error("restart while hot"); // [R11]
   a_alert_low: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      (|iout_st) |-> !alert_output_pin_n_out) else $error("alert not low with fault"); // [R16]
   a_sticky_bits: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      temp_st[7] && !clr |=> temp_st[7]) else $error("fault bit dropped"); // [R16]
endmodule // flm_monitor
`default_nettype wire

// ===== bench/flm_host.sv
// Host command master model for the limit monitor
`timescale 1ns/1ps
`default_nettype none
module flm_host (
   input wire logic mclk_in,
   input wire logic ack_in,
   input wire logic reject_in,
   input wire logic [15:0] rdata_in,
   output var flm_pkg::flm_cmd_t cmd_out
);
   logic timed_out;
   initial begin
      cmd_out = '0;
      timed_out = 1'b0;
   end
   // One command per call; warning limits are never raised above the fault limits
   task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] wdata,
         output logic [15:0] rdata, output logic rej);
      int i;
      timed_out = 1'b1;
      @(negedge mclk_in);
      cmd_out = '{wr: wr, rd: !wr, code: code, wdata: wdata};
      @(negedge mclk_in);
      // Strobes drop, payload inverted so a stale value is never mistaken
      cmd_out = '{wr: 1'b0, rd: 1'b0, code: ~code, wdata: ~wdata};
      // Ack stands for one cycle only, so look before each wait
      for (i = 0; i < 4; i++) begin
         if (ack_in === 1'b1) begin
            timed_out = 1'b0;
            break;
         end
         @(negedge mclk_in);
      end
      rdata = rdata_in;
      rej = reject_in;
   endtask
endmodule // flm_host
`default_nettype wire

// ===== bench/tb_top.sv
// Self-checking testbench for the limit monitor
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic mclk_in, resetn_in, avg_oc, avg_uc, ack, rej, alert_n, dis, restart;
   flm_pkg::flm_cmd_t cmd;
   flm_pkg::flm_sample_t cur, temp;
   logic [3:0] consec;
   logic [15:0] rdata;
   logic [7:0] iout_st, temp_st, vend_st;
   int num_errors = 0;
   int check_count = 0;
   // Short retry unit keeps the hold period at tens of cycles
   flm_monitor #(.CNT_W(4), .RETRY_UNIT(10)) i_flm_monitor (.mclk_in(mclk_in),
      .resetn_in(resetn_in), .cmd_in(cmd), .cur_in(cur), .temp_in(temp),
      .consec_count_in(consec), .avg_oc_fault_in(avg_oc), .avg_uc_fault_in(avg_uc),
      .cmd_rdata_out(rdata), .cmd_ack_out(ack), .cmd_reject_out(rej),
      .alert_output_pin_n_out(alert_n), .iout_status_out(iout_st),
      .temp_status_out(temp_st), .vendor_status_out(vend_st),
      .output_disable_out(dis), .restart_out(restart));
   flm_host i_flm_host (.mclk_in(mclk_in), .ack_in(ack), .reject_in(rej),
      .rdata_in(rdata), .cmd_out(cmd));
   initial begin
      mclk_in = 1'b0;
      forever #25 mclk_in = ~mclk_in;
   end
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
         num_errors++;
      end
   endtask
   task automatic check_bit(input logic got, input logic exp);
      check_word({15'h0000, got}, {15'h0000, exp});
   endtask
   // Command through the host model, refusal flag and read data judged
   task automatic send(input logic wr, input logic [7:0] code, input logic [15:0] wd,
         input logic exp_rej, input logic [15:0] exp_rd);
      logic [15:0] rd;
      logic rj;
      i_flm_host.xfer(wr, code, wd, rd, rj);
      if (i_flm_host.timed_out) begin
         num_errors++;
         complete_run();
      end
      check_bit(rj, exp_rej);
      if (!wr)
         check_word(rd, exp_rd);
   endtask
   task automatic smp(input logic is_temp, input logic blank, input logic [15:0] v);
      @(negedge mclk_in);
      if (is_temp)
         temp = '{valid: 1'b1, blank_done: blank, value: v};
      else
         cur = '{valid: 1'b1, blank_done: blank, value: v};
      @(negedge mclk_in);
      temp = '{valid: 1'b0, blank_done: 1'b0, value: ~v};
      cur = '{valid: 1'b0, blank_done: 1'b0, value: ~v};
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge mclk_in);
   endtask
   task automatic clear_all();
      send(1'b1, flm_pkg::CMD_CLEAR_FAULTS, 16'h0000, 1'b0, 16'h0000);
      idle(1);
      check_word({iout_st, temp_st}, 16'h0000);
      check_bit(alert_n, 1'b1);
   endtask
   task automatic t_reset();
      send(1'b0, flm_pkg::CMD_OC_FAULT, 16'h0000, 1'b0, 16'hE2D0);
      send(1'b0, flm_pkg::CMD_OC_WARN, 16'h0000, 1'b0, 16'hDBC0);
      send(1'b0, flm_pkg::CMD_UC_FAULT, 16'h0000, 1'b0, 16'hE530);
      send(1'b0, flm_pkg::CMD_OT_FAULT, 16'h0000, 1'b0, 16'hEBE8);
      check_bit(alert_n, 1'b1);
      $display("test reset done");
   endtask
   // 100 A accepted, 101 A and sign-wrong or too-hot values refused
   task automatic t_range();
      send(1'b1, flm_pkg::CMD_OC_FAULT, 16'hF8C8, 1'b0, 16'h0000);
      send(1'b1, flm_pkg::CMD_OC_FAULT, 16'hF8CA, 1'b1, 16'h0000);
      send(1'b0, flm_pkg::CMD_OC_FAULT, 16'h0000, 1'b0, 16'hF8C8);
      send(1'b1, flm_pkg::CMD_OC_WARN, 16'hFFFF, 1'b1, 16'h0000);
      send(1'b1, flm_pkg::CMD_UC_FAULT, 16'h0001, 1'b1, 16'h0000);
      send(1'b1, flm_pkg::CMD_OT_FAULT, 16'h00B0, 1'b1, 16'h0000);
      send(1'b1, flm_pkg::CMD_OC_FAULT, 16'hE2D0, 1'b0, 16'h0000);
      $display("test range done");
   endtask
   // Two-sample run: a miss restarts it, a blanked sample neither counts nor restarts
   task automatic t_current();
      consec = 4'h2;
      smp(1'b0, 1'b1, 16'h02E0);
      smp(1'b0, 1'b1, 16'h0010);
      smp(1'b0, 1'b1, 16'h02E0);
      smp(1'b0, 1'b0, 16'h02E0);
      idle(1);
      check_word({8'h00, iout_st}, 16'h0000);
      smp(1'b0, 1'b1, 16'h02E0);
      idle(1);
      check_word({8'h00, iout_st}, 16'h00A0);
      check_bit(alert_n, 1'b0);
      send(1'b0, flm_pkg::CMD_STATUS_WORD, 16'h0000, 1'b0, 16'h4000);
      clear_all();
      smp(1'b0, 1'b1, 16'h0230);
      smp(1'b0, 1'b1, 16'h0230);
      idle(1);
      check_word({8'h00, iout_st}, 16'h0020);
      clear_all();
      smp(1'b0, 1'b1, 16'hFD20);
      smp(1'b0, 1'b1, 16'hFD20);
      idle(1);
      check_word({8'h00, iout_st}, 16'h0010);
      clear_all();
      @(negedge mclk_in) avg_oc = 1'b1;
      @(negedge mclk_in) avg_oc = 1'b0;
      avg_uc = 1'b1;
      @(negedge mclk_in) avg_uc = 1'b0;
      check_word({8'h00, iout_st}, 16'h0090);
      clear_all();
      $display("test current done");
   endtask
   task automatic t_ot_latch();
      smp(1'b1, 1'b1, 16'h07E0);
      idle(1);
      check_word({temp_st, vend_st}, 16'h8002);
      check_bit(dis, 1'b1);
      check_bit(alert_n, 1'b0);
      send(1'b0, flm_pkg::CMD_STATUS_WORD, 16'h0000, 1'b0, 16'h0004);
      clear_all();
      idle(1);
      check_bit(dis, 1'b0);
      $display("test ot latch done");
   endtask
   task automatic count_restart(input int n, output int c);
      c = 0;
      // Restart pulse may already stand when called; look before waiting
      repeat (n) begin
         if (restart === 1'b1)
            c++;
         @(negedge mclk_in);
      end
   endtask
   // Delay code 1 gives 20 cycles; restart also waits for a sample under 110 C
   task automatic t_ot_retry();
      int c;
      send(1'b1, flm_pkg::CMD_OT_ACTION, 16'h0089, 1'b0, 16'h0000);
      smp(1'b1, 1'b1, 16'h07E0);
      smp(1'b1, 1'b1, 16'h0640);
      count_restart(15, c);
      check_word(16'(c), 16'h0000);
      idle(10);
      smp(1'b1, 1'b1, 16'h0730);
      count_restart(4, c);
      check_word(16'(c), 16'h0000);
      smp(1'b1, 1'b1, 16'h0640);
      count_restart(4, c);
      check_word(16'(c), 16'h0001);
      check_bit(dis, 1'b0);
      clear_all();
      $display("test ot retry done");
   endtask
   initial begin
      #3ms;
      num_errors++;
      complete_run();
   end
   initial begin
      resetn_in = 1'b0;
      cur = '0;
      temp = '0;
      consec = 4'h1;
      avg_oc = 1'b0;
      avg_uc = 1'b0;
      repeat (5) @(posedge mclk_in);
      @(negedge mclk_in) resetn_in = 1'b1;
      t_reset();
      t_range();
      t_current();
      t_ot_latch();
      t_ot_retry();
      complete_run();
   end
endmodule // tb_top
`default_nettype wire
